//--- verilog/pced_pkg.sv
// Constants shared by the pin change edge detector design.
`default_nettype none

package pced_pkg;

    // Register byte offsets on the AHB-Lite bus.
    localparam logic [7:0] PCED_OFF_RISE_A  = 8'h00;
    localparam logic [7:0] PCED_OFF_FALL_A  = 8'h04;
    localparam logic [7:0] PCED_OFF_FLAGS_A = 8'h08;
    localparam logic [7:0] PCED_OFF_RISE_C  = 8'h0c;
    localparam logic [7:0] PCED_OFF_FALL_C  = 8'h10;
    localparam logic [7:0] PCED_OFF_FLAGS_C = 8'h14;
    localparam logic [7:0] PCED_OFF_CTRL    = 8'h18;
    localparam logic [7:0] PCED_OFF_MODDIS  = 8'h1c;
    localparam logic [7:0] PCED_OFF_LEVEL   = 8'h20;
    localparam logic [7:0] PCED_OFF_IRQ_ST  = 8'h24;
    localparam logic [7:0] PCED_OFF_IRQ_EN  = 8'h28;
    localparam logic [7:0] PCED_OFF_IRQ_CLR = 8'h2c;

    // Field positions.
    localparam int PCED_CTRL_IRQEN_BIT = 0;
    localparam int PCED_CTRL_SUM_BIT   = 1;
    localparam int PCED_MODDIS_BIT     = 0;
    localparam int PCED_LEVEL_C_LSB    = 8;
    localparam int PCED_IST_CHANGE_BIT = 0;
    localparam int PCED_IST_WAKE_BIT   = 1;
    localparam int PCED_IST_WIDTH      = 2;

    // Reset values.
    localparam logic [7:0] PCED_ENABLE_RESET = 8'h00;
    localparam logic [7:0] PCED_FLAG_RESET   = 8'h00;

    // Samples needed before edge comparison is trusted.
    localparam logic [1:0] PCED_PRIME_COUNT = 2'h3;

    // Data phase state of the bus slave.
    typedef enum logic [1:0] {
        PCED_PH_IDLE = 2'b00,
        PCED_PH_WR   = 2'b01,
        PCED_PH_RD   = 2'b10
    } pced_phase_t;

endpackage : pced_pkg

`default_nettype wire

//--- verilog/pced_pin_detector.sv
// Synchroniser and rising/falling edge detector for one port of pins.
`default_nettype none

module pced_pin_detector #(
    parameter int WIDTH = 6
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             hold,
    input  wire logic [WIDTH-1:0] pins,
    input  wire logic [WIDTH-1:0] riseEn,
    input  wire logic [WIDTH-1:0] fallEn,
    output logic      [WIDTH-1:0] edgeHit,
    output logic      [WIDTH-1:0] level
);
    import pced_pkg::*;

    logic [WIDTH-1:0] syncFirst;
    logic [WIDTH-1:0] syncSecond;
    logic [WIDTH-1:0] prevSample;
    logic [1:0]       primeCnt;
    logic             primed;
    logic [WIDTH-1:0] riseSeen;
    logic [WIDTH-1:0] fallSeen;

    // Two-stage synchroniser, then one more stage to hold the previous sample.
    always_ff @(posedge clk) begin
        if (!rst_n || hold) begin
            syncFirst  <= '0;
            syncSecond <= '0;
            prevSample <= '0;
        end else begin
            syncFirst  <= pins;
            syncSecond <= syncFirst;
            prevSample <= syncSecond;
        end
    end

    // The compare waits until all stages carry real pin samples, so a pin
    // that is already high at reset release does not look like a rise.
    always_ff @(posedge clk) begin
        if (!rst_n || hold) begin
            primeCnt <= 2'h0;
        end else if (!primed) begin
            primeCnt <= primeCnt + 2'h1;
        end
    end

    assign primed   = (primeCnt == PCED_PRIME_COUNT);
    assign riseSeen = syncSecond & ~prevSample;
    assign fallSeen = ~syncSecond & prevSample;

    // Each pin has its own rise and fall detector; both may be on at once.
    assign edgeHit = primed ? ((riseSeen & riseEn) | (fallSeen & fallEn)) : '0;
    assign level   = syncSecond;

endmodule : pced_pin_detector

`default_nettype wire

//--- verilog/pced_top.sv
// Pin change edge detector with AHB-Lite registers, interrupt and wake.
// Each register is one 32-bit word at a byte offset from the block base.
// Offset 0x00 holds the port A rise enables and 0x04 the port A fall enables.
// Offset 0x08 holds the port A change flags, one per pin.
// Offsets 0x0c, 0x10 and 0x14 hold the same three registers for port C.
// Offset 0x18 is control: bit 0 enables the interrupt, bit 1 shows the summary.
// Offset 0x1c holds the module disable in bit 0.
// Offset 0x20 reads the pin levels, port A in bits 5:0 and port C in bits 13:8.
// Offset 0x24 is event status: bit 0 is any enabled edge, bit 1 a wake event.
// Offset 0x28 enables those events, and writing ones to 0x2c clears them.
// Unmapped and unaligned addresses read zero and ignore writes.
// While disabled, the port registers read zero and ignore writes.
// Control, disable and event registers are not touched by the disable.
// Reads take one wait state so that read data comes from a flip-flop.
// Writes take none and land at the end of their data phase.
// A flag write stores the written value ORed with same-cycle edges.
`default_nettype none

module pced_top #(
    parameter int PINS_A = 6,
    parameter int PINS_C = 6
) (
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [PINS_A-1:0] portAPins,
    input  wire logic [PINS_C-1:0] portCPins,
    input  wire logic              sleepMode,
    input  wire logic              hsel,
    input  wire logic [31:0]       haddr,
    input  wire logic [1:0]        htrans,
    input  wire logic              hwrite,
    input  wire logic [2:0]        hsize,
    input  wire logic [31:0]       hwdata,
    input  wire logic              hready,
    output logic      [31:0]       hrdata,
    output logic                   hreadyout,
    output logic                   hresp,
    output logic                   changeIrq,
    output logic                   changeSummary,
    output logic                   wakeReq,
    output logic                   irq
);
    import pced_pkg::*;

    // Bus slave state.
    pced_phase_t phase;
    logic [7:0]  addr;
    logic        addrHit;

    // Software visible state.
    logic [PINS_A-1:0] riseEnableA;
    logic [PINS_A-1:0] fallEnableA;
    logic [PINS_A-1:0] changeFlagsA;
    logic [PINS_C-1:0] riseEnableC;
    logic [PINS_C-1:0] fallEnableC;
    logic [PINS_C-1:0] changeFlagsC;
    logic              changeIrqEnable;
    logic              moduleDisable;
    logic [PCED_IST_WIDTH-1:0] irqStatus;
    logic [PCED_IST_WIDTH-1:0] irqEnable;

    // Detector outputs.
    logic [PINS_A-1:0] edgeA;
    logic [PINS_C-1:0] edgeC;
    logic [PINS_A-1:0] levelA;
    logic [PINS_C-1:0] levelC;

    // Next values and decode.
    logic [PINS_A-1:0] next_changeFlagsA;
    logic [PINS_C-1:0] next_changeFlagsC;
    logic [PCED_IST_WIDTH-1:0] next_irqStatus;
    logic [PCED_IST_WIDTH-1:0] irqEvents;
    logic [PCED_IST_WIDTH-1:0] clearMask;
    logic [31:0] readValue;
    logic        addrPhase;
    logic        wrActive;
    logic        wrRiseA;
    logic        wrFallA;
    logic        wrFlagsA;
    logic        wrRiseC;
    logic        wrFallC;
    logic        wrFlagsC;
    logic        wrCtrl;
    logic        wrModDis;
    logic        wrIrqEn;
    logic        wrIrqClr;
    logic        changeWritable;
    logic        anyFlag;
    logic        anyEdge;
    logic        wakeEvent;
    logic        detectHold;

    // Read selects, one per readable register, and the composed words.
    logic        rdRiseA;
    logic        rdFallA;
    logic        rdFlagsA;
    logic        rdRiseC;
    logic        rdFallC;
    logic        rdFlagsC;
    logic        rdCtrl;
    logic        rdModDis;
    logic        rdLevel;
    logic        rdIrqSt;
    logic        rdIrqEn;
    logic [31:0] levelWord;
    logic [31:0] ctrlWord;

    // While disabled, the detectors and change registers sit in reset.
    assign detectHold = moduleDisable;

    // One detector per port.
    pced_pin_detector #(
        .WIDTH (PINS_A)
    ) u_detect_a (
        .clk     (clk),
        .rst_n   (rst_n),
        .hold    (detectHold),
        .pins    (portAPins),
        .riseEn  (riseEnableA),
        .fallEn  (fallEnableA),
        .edgeHit (edgeA),
        .level   (levelA)
    );

    pced_pin_detector #(
        .WIDTH (PINS_C)
    ) u_detect_c (
        .clk     (clk),
        .rst_n   (rst_n),
        .hold    (detectHold),
        .pins    (portCPins),
        .riseEn  (riseEnableC),
        .fallEn  (fallEnableC),
        .edgeHit (edgeC),
        .level   (levelC)
    );

    // A transfer is taken when selected, NONSEQ or SEQ, and the bus is ready.
    assign addrPhase = hsel && htrans[1] && hready;

    // Data phase tracking; reads take one wait state so that hrdata
    // comes from a flip-flop and sees every earlier write.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            phase   <= PCED_PH_IDLE;
            addr    <= 8'h00;
            addrHit <= 1'b0;
        end else if (addrPhase) begin
            phase   <= hwrite ? PCED_PH_WR : PCED_PH_RD;
            addr    <= haddr[7:0];
            addrHit <= (haddr[31:8] == 24'h000000) && (haddr[1:0] == 2'b00);
        end else if (phase == PCED_PH_WR || hreadyout) begin
            phase   <= PCED_PH_IDLE;
        end
    end

    // Ready drops only for the first cycle of a read data phase.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hreadyout <= 1'b1;
        end else if (addrPhase && !hwrite) begin
            hreadyout <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
        end
    end

    // Read data is loaded in the wait cycle; the answer is always OKAY.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            hrdata <= 32'h00000000;
            hresp  <= 1'b0;
        end else begin
            hresp  <= 1'b0;
            if (phase == PCED_PH_RD && !hreadyout) begin
                hrdata <= readValue;
            end
        end
    end

    // Write strobes, one per writable register, in the write data phase.
    assign wrActive    = (phase == PCED_PH_WR) && addrHit;
    assign changeWritable = wrActive && !moduleDisable;
    assign wrRiseA     = changeWritable && (addr == PCED_OFF_RISE_A);
    assign wrFallA     = changeWritable && (addr == PCED_OFF_FALL_A);
    assign wrFlagsA    = changeWritable && (addr == PCED_OFF_FLAGS_A);
    assign wrRiseC     = changeWritable && (addr == PCED_OFF_RISE_C);
    assign wrFallC     = changeWritable && (addr == PCED_OFF_FALL_C);
    assign wrFlagsC    = changeWritable && (addr == PCED_OFF_FLAGS_C);
    assign wrCtrl      = wrActive && (addr == PCED_OFF_CTRL);
    assign wrModDis    = wrActive && (addr == PCED_OFF_MODDIS);
    assign wrIrqEn     = wrActive && (addr == PCED_OFF_IRQ_EN);
    assign wrIrqClr    = wrActive && (addr == PCED_OFF_IRQ_CLR);

    // Edge enables; bits above the pin count do not exist and read zero.
    always_ff @(posedge clk) begin
        if (!rst_n || moduleDisable) begin
            riseEnableA <= PCED_ENABLE_RESET[PINS_A-1:0];
            fallEnableA <= PCED_ENABLE_RESET[PINS_A-1:0];
            riseEnableC <= PCED_ENABLE_RESET[PINS_C-1:0];
            fallEnableC <= PCED_ENABLE_RESET[PINS_C-1:0];
        end else begin
            if (wrRiseA) begin
                riseEnableA <= hwdata[PINS_A-1:0];
            end
            if (wrFallA) begin
                fallEnableA <= hwdata[PINS_A-1:0];
            end
            if (wrRiseC) begin
                riseEnableC <= hwdata[PINS_C-1:0];
            end
            if (wrFallC) begin
                fallEnableC <= hwdata[PINS_C-1:0];
            end
        end
    end

    // Flags take the written value, but an edge in the same cycle wins,
    // so a masked clear never loses a fresh change.
    assign next_changeFlagsA = wrFlagsA ? (hwdata[PINS_A-1:0] | edgeA)
                                        : (changeFlagsA | edgeA);
    assign next_changeFlagsC = wrFlagsC ? (hwdata[PINS_C-1:0] | edgeC)
                                        : (changeFlagsC | edgeC);

    // Flags keep updating whatever the interrupt enable or sleep state.
    always_ff @(posedge clk) begin
        if (!rst_n || moduleDisable) begin
            changeFlagsA <= PCED_FLAG_RESET[PINS_A-1:0];
            changeFlagsC <= PCED_FLAG_RESET[PINS_C-1:0];
        end else begin
            changeFlagsA <= next_changeFlagsA;
            changeFlagsC <= next_changeFlagsC;
        end
    end

    // Control: global change interrupt enable and the module disable bit.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            changeIrqEnable <= 1'b0;
            moduleDisable   <= 1'b0;
        end else begin
            if (wrCtrl) begin
                changeIrqEnable <= hwdata[PCED_CTRL_IRQEN_BIT];
            end
            if (wrModDis) begin
                moduleDisable <= hwdata[PCED_MODDIS_BIT];
            end
        end
    end

    // Summary across all ports and the events that feed the status register.
    assign anyFlag   = (|changeFlagsA) || (|changeFlagsC);
    assign anyEdge   = (|edgeA) || (|edgeC);
    assign wakeEvent = anyEdge && sleepMode && changeIrqEnable;

    always_comb begin
        irqEvents = '0;
        irqEvents[PCED_IST_CHANGE_BIT] = anyEdge;
        irqEvents[PCED_IST_WAKE_BIT]   = wakeEvent;
    end

    // Sticky status: a new event in the clearing cycle stays set.
    assign clearMask      = wrIrqClr ? hwdata[PCED_IST_WIDTH-1:0] : '0;
    assign next_irqStatus = (irqStatus & ~clearMask) | irqEvents;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irqStatus <= '0;
            irqEnable <= '0;
        end else begin
            irqStatus <= next_irqStatus;
            if (wrIrqEn) begin
                irqEnable <= hwdata[PCED_IST_WIDTH-1:0];
            end
        end
    end

    // Registered outputs toward the core.
    // Each one follows its source by one clock, so none of them glitches.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            changeSummary <= 1'b0;
            changeIrq     <= 1'b0;
            wakeReq       <= 1'b0;
            irq           <= 1'b0;
        end else begin
            changeSummary <= anyFlag;
            changeIrq     <= anyFlag && changeIrqEnable;
            wakeReq       <= anyFlag && changeIrqEnable && sleepMode;
            irq           <= |(irqStatus & irqEnable);
        end
    end

    // Read selects; a miss or an unaligned address selects nothing and reads zero.
    assign rdRiseA  = addrHit && (addr == PCED_OFF_RISE_A);
    assign rdFallA  = addrHit && (addr == PCED_OFF_FALL_A);
    assign rdFlagsA = addrHit && (addr == PCED_OFF_FLAGS_A);
    assign rdRiseC  = addrHit && (addr == PCED_OFF_RISE_C);
    assign rdFallC  = addrHit && (addr == PCED_OFF_FALL_C);
    assign rdFlagsC = addrHit && (addr == PCED_OFF_FLAGS_C);
    assign rdCtrl   = addrHit && (addr == PCED_OFF_CTRL);
    assign rdModDis = addrHit && (addr == PCED_OFF_MODDIS);
    assign rdLevel  = addrHit && (addr == PCED_OFF_LEVEL);
    assign rdIrqSt  = addrHit && (addr == PCED_OFF_IRQ_ST);
    assign rdIrqEn  = addrHit && (addr == PCED_OFF_IRQ_EN);

    // The level word is blanked while the module is off, like the port registers.
    assign levelWord = moduleDisable ? 32'h00000000 : 32'({levelC, 2'b00, levelA});
    assign ctrlWord  = 32'({anyFlag, changeIrqEnable});

    // Read selection; the selects are exclusive, so the order sets no priority.
    assign readValue =
        rdRiseA  ? 32'(riseEnableA) :
        rdFallA  ? 32'(fallEnableA) :
        rdFlagsA ? 32'(changeFlagsA) :
        rdRiseC  ? 32'(riseEnableC) :
        rdFallC  ? 32'(fallEnableC) :
        rdFlagsC ? 32'(changeFlagsC) :
        rdCtrl   ? ctrlWord :
        rdModDis ? 32'(moduleDisable) :
        rdLevel  ? levelWord :
        rdIrqSt  ? 32'(irqStatus) :
        rdIrqEn  ? 32'(irqEnable) :
                   32'h00000000;

endmodule : pced_top

`default_nettype wire

//--- test/pced_pin_model.sv
// Model of the external signals that drive the two ports.
`default_nettype none
module pced_pin_model #(
    parameter int W = 6
) (
    input  wire logic         clk,
    input  wire logic [W-1:0] levelA,
    input  wire logic [W-1:0] levelC,
    input  wire logic [W-1:0] toggleA,
    output logic      [W-1:0] portAPins,
    output logic      [W-1:0] portCPins
);
    timeunit 1ns;
    timeprecision 1ps;
    // Pins start low so no edge is seen at power up.
    initial begin
        portAPins = '0;
        portCPins = '0;
    end
    // Pins move just after an edge; a toggled pin flips every cycle.
    always @(posedge clk) begin
        portAPins <= (levelA & ~toggleA) | (~portAPins & toggleA);
        portCPins <= levelC;
    end
endmodule : pced_pin_model
`default_nettype wire

//--- test/pced_chk.sv
// Concurrent checks on the ports of the pin change edge detector.
`default_nettype none
module pced_chk #(
    parameter int PINS_A = 6,
    parameter int PINS_C = 6
) (
    input wire logic              clk,
    input wire logic              rst_n,
    input wire logic [PINS_A-1:0] portAPins,
    input wire logic [PINS_C-1:0] portCPins,
    input wire logic              sleepMode,
    input wire logic              hsel,
    input wire logic [31:0]       haddr,
    input wire logic [1:0]        htrans,
    input wire logic              hwrite,
    input wire logic              hreadyout,
    input wire logic              hresp,
    input wire logic              changeIrq,
    input wire logic              changeSummary,
    input wire logic              wakeReq
);
    timeunit 1ns;
    timeprecision 1ps;
    import pced_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire taken = hsel & htrans[1] & hreadyout;
    logic [PINS_A-1:0] lastA;
    logic [PINS_C-1:0] lastC;
    logic [2:0] quiet;
    logic wrCtrl;
    // Quiet counts cycles with no pin move and no transfer; wrCtrl marks a control write.
    always_ff @(posedge clk) begin
        lastA <= portAPins;
        lastC <= portCPins;
        wrCtrl <= rst_n & taken & hwrite & (haddr[7:0] == PCED_OFF_CTRL);
        if (!rst_n || taken || lastA != portAPins || lastC != portCPins) begin
            quiet <= 3'h0;
        end else if (quiet != 3'h7) begin
            quiet <= quiet + 3'h1;
        end
    end
    sequence rdTaken;
        taken && !hwrite;
    endsequence
    sequence rdWait;
        !hreadyout ##1 hreadyout;
    endsequence
    chk_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
    chk_read_wait: assert property (rdTaken |=> rdWait) else $error("read wait wrong");
    chk_write_ready: assert property (taken && hwrite |=> hreadyout) else $error("write stalled");
    chk_ready_idle: assert property (!(taken && !hwrite) |=> hreadyout) else $error("stray wait");
    chk_summary_cause: assert property ($rose(changeSummary) |-> quiet < 3'h7)
        else $error("summary rose with no cause");
    chk_irq_summary: assert property (changeIrq |-> changeSummary) else $error("irq without flag");
    chk_irq_cause: assert property ($rose(changeIrq) |-> $rose(changeSummary) || $past(wrCtrl, 2))
        else $error("irq rose without cause");
    chk_wake_gate: assert property (wakeReq |-> changeIrq && $past(sleepMode))
        else $error("wake not gated");
endmodule : pced_chk
bind pced_top pced_chk #(.PINS_A(PINS_A), .PINS_C(PINS_C)) chk (.clk(clk), .rst_n(rst_n),
    .portAPins(portAPins), .portCPins(portCPins), .sleepMode(sleepMode), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout), .hresp(hresp), .changeIrq(changeIrq),
    .changeSummary(changeSummary), .wakeReq(wakeReq));
`default_nettype wire

//--- test/pced_top_tb.sv
// Self-checking testbench for the pin change edge detector.
`default_nettype none
module pced_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import pced_pkg::*;
    logic clk, rst_n, sleepMode, hsel, hwrite, hreadyout, hresp, changeIrq, changeSummary, wakeReq, irq;
    logic [31:0] haddr, hwdata, hrdata, v, w;
    logic [1:0]  htrans;
    logic [5:0]  portAPins, portCPins, levelA, levelC, toggleA;
    int          nMismatch, numChecks;
    pced_top dut (.clk(clk), .rst_n(rst_n), .portAPins(portAPins), .portCPins(portCPins),
        .sleepMode(sleepMode), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
        .hresp(hresp), .changeIrq(changeIrq), .changeSummary(changeSummary), .wakeReq(wakeReq), .irq(irq));
    pced_pin_model pins_m (.clk(clk), .levelA(levelA), .levelC(levelC), .toggleA(toggleA),
        .portAPins(portAPins), .portCPins(portCPins));
    // The clock runs at 100 MHz.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", numChecks, nMismatch);
        if (nMismatch == 0 && numChecks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : end_of_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            nMismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One single AHB-Lite transfer; read data is taken at the edge that ends the data phase.
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : bus
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, w);
    endtask : wr
    task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
        bus(1'b0, a, 32'h0, v);
        check(v, exp);
    endtask : rchk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic pins(input logic [5:0] a, input logic [5:0] c);
        @(posedge clk);
        levelA <= a;
        levelC <= c;
        cyc(8);
    endtask : pins
    // A hang ends the run as a failure.
    initial begin
        #100000;
        nMismatch++;
        end_of_test();
    end
    // Main sequence.
    initial begin
        {rst_n, sleepMode, hsel, hwrite, htrans, haddr, hwdata} = '0;
        {levelA, levelC, toggleA, nMismatch, numChecks} = '0;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        pins(6'h02, 6'h00);
        rchk(PCED_OFF_RISE_A, 32'h0);
        rchk(PCED_OFF_FALL_A, 32'h0);
        wr(PCED_OFF_RISE_A, 32'hff);
        wr(PCED_OFF_FALL_A, 32'hff);
        rchk(PCED_OFF_RISE_A, 32'h3f);
        rchk(PCED_OFF_FALL_A, 32'h3f);
        rchk(8'h30, 32'h0);
        $display("test registers done");
        wr(PCED_OFF_RISE_A, 32'h05);
        wr(PCED_OFF_FALL_A, 32'h06);
        wr(PCED_OFF_RISE_C, 32'h01);
        rchk(PCED_OFF_RISE_C, 32'h01);
        pins(6'h0d, 6'h01);
        rchk(PCED_OFF_FLAGS_A, 32'h07);
        rchk(PCED_OFF_FLAGS_C, 32'h01);
        check(changeIrq, 1'b0);
        wr(PCED_OFF_FLAGS_A, 32'h0);
        rchk(PCED_OFF_FLAGS_A, 32'h0);
        check(changeSummary, 1'b1);
        wr(PCED_OFF_FLAGS_C, 32'h0);
        cyc(2);
        check(changeSummary, 1'b0);
        pins(6'h02, 6'h01);
        rchk(PCED_OFF_FLAGS_A, 32'h04);
        $display("test edges done");
        bus(1'b0, PCED_OFF_FLAGS_A, 32'h0, w);
        pins(6'h03, 6'h01);
        bus(1'b0, PCED_OFF_FLAGS_A, 32'h0, v);
        wr(PCED_OFF_FLAGS_A, v & ~w);
        rchk(PCED_OFF_FLAGS_A, 32'h01);
        wr(PCED_OFF_FLAGS_A, 32'h0);
        toggleA <= 6'h04;
        cyc(4);
        wr(PCED_OFF_FLAGS_A, 32'h0);
        repeat (4) begin
            @(posedge clk);
            check(changeSummary, 1'b1);
        end
        toggleA <= 6'h00;
        $display("test clearing done");
        wr(PCED_OFF_CTRL, 32'h1);
        cyc(2);
        check(changeIrq, 1'b1);
        wr(PCED_OFF_IRQ_EN, 32'h1);
        pins(6'h07, 6'h01);
        check(irq, 1'b1);
        rchk(PCED_OFF_IRQ_ST, 32'h1);
        wr(PCED_OFF_IRQ_EN, 32'h0);
        cyc(2);
        check(irq, 1'b0);
        wr(PCED_OFF_IRQ_CLR, 32'h1);
        rchk(PCED_OFF_IRQ_ST, 32'h0);
        $display("test interrupt done");
        wr(PCED_OFF_FLAGS_A, 32'h0);
        sleepMode <= 1'b1;
        cyc(4);
        check(wakeReq, 1'b0);
        pins(6'h03, 6'h01);
        check(wakeReq, 1'b1);
        rchk(PCED_OFF_FLAGS_A, 32'h04);
        rchk(PCED_OFF_IRQ_ST, 32'h3);
        wr(PCED_OFF_CTRL, 32'h0);
        cyc(2);
        check(wakeReq, 1'b0);
        sleepMode <= 1'b0;
        $display("test sleep done");
        rchk(PCED_OFF_LEVEL, 32'h00000103);
        wr(PCED_OFF_MODDIS, 32'h1);
        rchk(PCED_OFF_LEVEL, 32'h0);
        rchk(PCED_OFF_RISE_A, 32'h0);
        rchk(PCED_OFF_FLAGS_A, 32'h0);
        wr(PCED_OFF_RISE_A, 32'h3f);
        pins(6'h07, 6'h00);
        rchk(PCED_OFF_RISE_A, 32'h0);
        wr(PCED_OFF_MODDIS, 32'h0);
        rchk(PCED_OFF_FLAGS_A, 32'h0);
        $display("test disable done");
        end_of_test();
    end
endmodule : pced_top_tb
`default_nettype wire
